// ---- rtl/lcf_pkg.sv ----
// Overview of operation
// RQ1: wait 3 after activate/precharge, 2 after modeset, 12/10 after refresh.
// RQ2: read without auto-close completes after half burst plus read latency.
// RQ3: read with auto-close waits for the larger of two completion counts.
// RQ4: write takes one plus half burst plus recovery: 6, auto-close 9.
// RQ5: clock rate may change only in self refresh, power-down or clock stop.
// RQ6: after new clock settles, controller meets low-power exit timing.
// RQ7: a continuously drifting clock is not stable and not supported.
// RQ8: enable low on two edges keeps the low-power state, any command.
// RQ9: enable rise with nop leaves power-down/self refresh; deep exit always.
// RQ10: after deep power-down the controller repeats full initialization.
// RQ11: enable fall enters power-down, self refresh or deep power-down.
// RQ12: controller sends only nop or deselect during exit delays.
// RQ13: deselect and nop let the operation in progress continue.
// RQ14: idle bank decodes activate, auto refresh and mode register set.
// RQ15: active bank decodes read, write and precharge.
// RQ16: read burst cut by read, write, precharge; burst terminate ends it.
// RQ17: write burst truncated by read, write or precharge.
// RQ18: controller issues no command outside the truth tables.
// RQ19: refresh, self refresh and modeset only with all banks idle.
// RQ20: burst terminate acts on the latest read burst.
// RQ21: controller masks write data cut off by a read.
// RQ22: commands register only when enable was high on both edges.
// RQ23: controller rounds nanosecond timings up to whole cycles.
package lcf_pkg;
  // command codes {ras_n, cas_n, we_n} with select low
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_BST = 3'h6;
  // default timing counts in link cycles
  localparam int ACT_TO_RW_DELAY = 3;
  localparam int PRECHARGE_PERIOD = 3;
  localparam int MODESET_DELAY = 2;
  localparam int REFRESH_CYCLE_TIME = 12;
  localparam int BURST_LEN = 4;
  localparam int READ_LATENCY = 3;
  // recovery terms chosen so 1 + half burst + recovery gives 6 and 9
  localparam int WRITE_RECOVERY = 3;
  localparam int WRITE_AUTOCLOSE_RECOVERY = 6;
  localparam int CNT_W = 8;
  // state encodings seen on the status port
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ACTIVATING = 4'h1, ST_ACTIVE = 4'h3,
    ST_READ = 4'h2, ST_WRITE = 4'h6, ST_PRECHARGING = 4'h7,
    ST_REFRESH = 4'h5, ST_MODESET = 4'h4, ST_PD_PRE = 4'hc,
    ST_PD_ACT = 4'hd, ST_SELFREF = 4'hf, ST_DEEP_PD = 4'he,
    ST_READ_AC = 4'ha, ST_WRITE_AC = 4'hb
  } lcf_state_type;
endpackage

// ---- rtl/lcf_sync.sv ----
// two-flop level synchroniser into the core domain
module lcf_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [W-1:0] d, // level from other domain
  output logic [W-1:0] q // synchronised level
);
  logic [W-1:0] meta_q;
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // lcf_sync

// ---- rtl/lcf_timer.sv ----
// down counter: busy while a completion count runs
module lcf_timer #(
  parameter int W = 8
) (
  input wire logic clk, // link clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic load, // start a new count
  input wire logic [W-1:0] count, // cycles to wait
  output logic busy // count still running
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  assign cnt_d = load ? count :
                 (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  // a count of n holds the caller for exactly n edges after the load
  assign busy = (cnt_q > W'(1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule // lcf_timer

// ---- rtl/lcf_fsm.sv ----
// command and power-state engine of one bank, clocked by the link clock
module lcf_fsm #(
  parameter int BURST_LEN = lcf_pkg::BURST_LEN, // burst length
  parameter int READ_LATENCY = lcf_pkg::READ_LATENCY, // read latency
  parameter int PRECHARGE_PERIOD = lcf_pkg::PRECHARGE_PERIOD,
  parameter int ACT_TO_RW_DELAY = lcf_pkg::ACT_TO_RW_DELAY,
  parameter int MODESET_DELAY = lcf_pkg::MODESET_DELAY,
  parameter int REFRESH_CYCLE_TIME = lcf_pkg::REFRESH_CYCLE_TIME,
  parameter int WRITE_RECOVERY = lcf_pkg::WRITE_RECOVERY,
  parameter int WRITE_AUTOCLOSE_RECOVERY =
    lcf_pkg::WRITE_AUTOCLOSE_RECOVERY
) (
  input wire logic CORE_CLK, // core clock, 50 MHz
  input wire logic ARST_N, // asynchronous reset, active low
  input wire logic LINK_CLK, // memory clock from the controller
  input wire logic CKE, // clock enable
  input wire logic CS_N, // chip select, active low
  input wire logic RAS_N, // row strobe, active low
  input wire logic CAS_N, // column strobe, active low
  input wire logic WE_N, // write strobe, active low
  input wire logic AUTO_CLOSE, // auto-close address bit on read/write
  output logic [3:0] LINK_STATE, // state, link domain
  output logic CMD_VALID, // command registered this link cycle
  output logic [2:0] CMD_CODE, // registered command code
  output logic BURST_ACTIVE, // read or write burst running, link domain
  output logic [3:0] CORE_STATE, // state, synchronised to core clock
  output logic CORE_LOW_POWER, // in any low-power state, core domain
  output logic CORE_FREQ_OK // clock change now allowed, core domain
);
  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam int HALF_BL = BURST_LEN / 2;
  localparam int RD_CNT = HALF_BL + READ_LATENCY;
  localparam int RDAC_A = HALF_BL + PRECHARGE_PERIOD;
  localparam int RDAC_CNT = (RDAC_A > RD_CNT) ? RDAC_A : RD_CNT; // [RQ3]
  localparam int WR_CNT = 1 + HALF_BL + WRITE_RECOVERY; // [RQ4]
  localparam int WRAC_CNT = 1 + HALF_BL + WRITE_AUTOCLOSE_RECOVERY;
  localparam int CW = lcf_pkg::CNT_W;

  // ****************************************************************
  // pin capture and command decode
  // ****************************************************************
  logic cke_prev_q;
  lcf_pkg::lcf_state_type state_q, state_d;
  logic [CW-1:0] ld_cnt;
  logic ld;
  logic busy;
  logic last_rd_q;
  logic last_rd_d;

  wire sel = !CS_N; // deselect when high [RQ13]
  wire [2:0] code = {RAS_N, CAS_N, WE_N};
  wire is_nop = !sel || code == lcf_pkg::CMD_NOP; // [RQ13]
  wire run = cke_prev_q && CKE; // commands only with both high [RQ22]
  wire cke_fall = cke_prev_q && !CKE;
  wire cke_rise = !cke_prev_q && CKE;
  wire cmd_act = run && sel && code == lcf_pkg::CMD_ACT;
  wire cmd_rd = run && sel && code == lcf_pkg::CMD_RD;
  wire cmd_wr = run && sel && code == lcf_pkg::CMD_WR;
  wire cmd_pre = run && sel && code == lcf_pkg::CMD_PRE;
  wire cmd_ref = sel && code == lcf_pkg::CMD_REF;
  wire cmd_mrs = run && sel && code == lcf_pkg::CMD_MRS;
  wire cmd_bst = sel && code == lcf_pkg::CMD_BST;
  wire in_read = state_q == lcf_pkg::ST_READ;
  wire in_write = state_q == lcf_pkg::ST_WRITE;

  // previous enable sample, compared at every edge
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) cke_prev_q <= 1'b0;
    else cke_prev_q <= CKE; // [RQ8]
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // read/write start used by both active and burst states
  function automatic lcf_pkg::lcf_state_type rw_state(input logic wr,
                                                      input logic ac);
    if (wr) rw_state = ac ? lcf_pkg::ST_WRITE_AC : lcf_pkg::ST_WRITE;
    else rw_state = ac ? lcf_pkg::ST_READ_AC : lcf_pkg::ST_READ;
  endfunction

  function automatic logic [CW-1:0] rw_count(input logic wr,
                                             input logic ac);
    if (wr) rw_count = ac ? CW'(WRAC_CNT) : CW'(WR_CNT);
    else rw_count = ac ? CW'(RDAC_CNT) : CW'(RD_CNT);
  endfunction

  always_comb begin
    state_d = state_q;
    ld = 1'b0;
    ld_cnt = '0;
    last_rd_d = last_rd_q;
    case (state_q)
      lcf_pkg::ST_IDLE: begin
        if (cke_fall && is_nop) begin
          state_d = lcf_pkg::ST_PD_PRE; // [RQ11]
        end else if (cke_fall && cmd_ref) begin
          state_d = lcf_pkg::ST_SELFREF; // [RQ11]
        end else if (cke_fall && cmd_bst) begin
          state_d = lcf_pkg::ST_DEEP_PD; // [RQ11]
        end else if (cmd_act) begin
          state_d = lcf_pkg::ST_ACTIVATING; // [RQ14]
          ld = 1'b1;
          ld_cnt = CW'(ACT_TO_RW_DELAY);
        end else if (run && cmd_ref) begin
          state_d = lcf_pkg::ST_REFRESH; // [RQ14]
          ld = 1'b1;
          ld_cnt = CW'(REFRESH_CYCLE_TIME);
        end else if (cmd_mrs) begin
          state_d = lcf_pkg::ST_MODESET; // [RQ14]
          ld = 1'b1;
          ld_cnt = CW'(MODESET_DELAY);
        end
      end
      lcf_pkg::ST_ACTIVE: begin
        if (cke_fall && is_nop) begin
          state_d = lcf_pkg::ST_PD_ACT; // [RQ11]
        end else if (cmd_rd || cmd_wr) begin
          state_d = rw_state(cmd_wr, AUTO_CLOSE); // [RQ15]
          ld = 1'b1;
          ld_cnt = rw_count(cmd_wr, AUTO_CLOSE);
          last_rd_d = cmd_rd;
        end else if (cmd_pre) begin
          state_d = lcf_pkg::ST_PRECHARGING; // [RQ15]
          ld = 1'b1;
          ld_cnt = CW'(PRECHARGE_PERIOD);
        end
      end
      lcf_pkg::ST_READ, lcf_pkg::ST_WRITE: begin
        if (cmd_rd || cmd_wr) begin
          state_d = rw_state(cmd_wr, AUTO_CLOSE); // [RQ16] [RQ17]
          ld = 1'b1;
          ld_cnt = rw_count(cmd_wr, AUTO_CLOSE);
          last_rd_d = cmd_rd;
        end else if (cmd_pre) begin
          state_d = lcf_pkg::ST_PRECHARGING; // [RQ16] [RQ17]
          ld = 1'b1;
          ld_cnt = CW'(PRECHARGE_PERIOD);
          last_rd_d = 1'b0;
        end else if (run && cmd_bst && in_read && last_rd_q) begin
          state_d = lcf_pkg::ST_ACTIVE; // [RQ16] [RQ20]
          last_rd_d = 1'b0;
        end else if (!busy) begin
          state_d = lcf_pkg::ST_ACTIVE; // burst ran out
          last_rd_d = 1'b0;
        end
      end
      lcf_pkg::ST_ACTIVATING: begin
        if (!busy) state_d = lcf_pkg::ST_ACTIVE;
      end
      lcf_pkg::ST_READ_AC, lcf_pkg::ST_WRITE_AC,
      lcf_pkg::ST_PRECHARGING, lcf_pkg::ST_REFRESH,
      lcf_pkg::ST_MODESET: begin
        if (!busy) begin
          state_d = lcf_pkg::ST_IDLE;
          last_rd_d = 1'b0;
        end
      end
      lcf_pkg::ST_PD_PRE, lcf_pkg::ST_PD_ACT,
      lcf_pkg::ST_SELFREF: begin
        // both low: stay; rise with nop: leave [RQ8] [RQ9]
        if (cke_rise && is_nop) begin
          state_d = (state_q == lcf_pkg::ST_PD_ACT) ?
                    lcf_pkg::ST_ACTIVE : lcf_pkg::ST_IDLE;
        end
      end
      lcf_pkg::ST_DEEP_PD: begin
        // data is lost; controller must reinitialise after this
        if (cke_rise) state_d = lcf_pkg::ST_IDLE; // [RQ9]
      end
      default: state_d = lcf_pkg::ST_IDLE;
    endcase
  end

  // ****************************************************************
  // link-domain registers
  // ****************************************************************
  lcf_timer #(.W(CW)) u_timer (
    .clk(LINK_CLK),
    .arst_n(ARST_N),
    .load(ld),
    .count(ld_cnt),
    .busy(busy)
  );

  // state and last-read tracking
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= lcf_pkg::ST_IDLE;
      last_rd_q <= 1'b0;
    end else begin
      state_q <= state_d;
      last_rd_q <= last_rd_d;
    end
  end

  // registered command report: valid only for run-mode commands, code for any selected one
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD_VALID <= 1'b0;
      CMD_CODE <= lcf_pkg::CMD_NOP;
    end else begin
      CMD_VALID <= run && sel && code != lcf_pkg::CMD_NOP; // [RQ22]
      CMD_CODE <= sel ? code : lcf_pkg::CMD_NOP;
    end
  end

  assign LINK_STATE = state_q;
  assign BURST_ACTIVE = in_read || in_write ||
                        state_q == lcf_pkg::ST_READ_AC ||
                        state_q == lcf_pkg::ST_WRITE_AC;

  // ****************************************************************
  // crossing to the core clock
  // ****************************************************************
  // gray-ordered codes change one bit on activate and read entry and on precharge entry from active or write,
  // up to four elsewhere; the core copy holds its old value one extra core cycle on every change
  logic [3:0] core_state_s;
  logic [3:0] core_prev_q;
  // a value seen twice running is past any mid-change mix of bits
  wire core_settled = core_state_s == core_prev_q;
  lcf_sync #(.W(4)) u_sync (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .d(state_q),
    .q(core_state_s)
  );

  wire core_lp = core_state_s == lcf_pkg::ST_PD_PRE ||
                 core_state_s == lcf_pkg::ST_PD_ACT ||
                 core_state_s == lcf_pkg::ST_SELFREF ||
                 core_state_s == lcf_pkg::ST_DEEP_PD;
  // clock stop allowed when idle/active with nothing pending
  wire core_stop = core_state_s == lcf_pkg::ST_IDLE ||
                   core_state_s == lcf_pkg::ST_ACTIVE;

  // registered core-domain status
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_STATE <= 4'h0;
      CORE_LOW_POWER <= 1'b0;
      CORE_FREQ_OK <= 1'b0;
      core_prev_q <= 4'h0;
    end else begin
      core_prev_q <= core_state_s;
      if (core_settled) begin
        CORE_STATE <= core_state_s;
        CORE_LOW_POWER <= core_lp;
        CORE_FREQ_OK <= (core_lp && core_state_s != lcf_pkg::ST_DEEP_PD)
                        || core_stop; // [RQ5]
      end
    end
  end
endmodule // lcf_fsm

// ---- sim/lcf_ctl_model.sv ----
// ****************************************
// memory controller side of the pins
// ****************************************
module lcf_ctl_model (
  output logic lclk, // link clock
  output logic cke, // clock enable
  output logic cs_n, // chip select, active low
  output logic ras_n, // row strobe, active low
  output logic cas_n, // column strobe, active low
  output logic we_n, // write strobe, active low
  output logic ac // auto-close bit
);
  timeunit 1ns;
  timeprecision 100ps;
  // fixed 6 ns clock, offset so it never lines up with the core clock
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end
  // parked deselected with enable low until the bench starts
  initial begin
    cke = 1'b0;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ac = 1'b0;
  end
  // counts are whole link cycles, rounded up no data path, so
  // masking of write data cut by a read is out of scope here
  // one command per link cycle, changed just after the edge; callers
  // only issue legal commands and pad waits with nops
  task automatic cmd(input logic [3:0] c, input logic k, input logic a);
    @(posedge lclk);
    #1;
    cke = k;
    cs_n = c[3];
    ac = a;
    // deselected strobes carry junk so a stale value cannot help
    if (c[3]) begin
      {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    end else begin
      {ras_n, cas_n, we_n} = c[2:0];
    end
  endtask
endmodule // lcf_ctl_model

// ---- sim/lcf_fsm_assertions.sv ----
// ****************************************
// link-side command checks
// ****************************************
module lcf_fsm_assertions (
  input wire logic CORE_CLK, // core clock
  input wire logic ARST_N, // reset, active low
  input wire logic LINK_CLK, // link clock
  input wire logic CKE, // clock enable
  input wire logic CS_N, // chip select, active low
  input wire logic RAS_N, // row strobe
  input wire logic CAS_N, // column strobe
  input wire logic WE_N, // write strobe
  input wire logic [3:0] LINK_STATE, // link state
  input wire logic CMD_VALID, // command pulse
  input wire logic [2:0] CMD_CODE // command code
);
  logic cke_q;
  // enable history resets low like the device's own
  always_ff @(posedge LINK_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= CKE;
    end
  end
  // decoded pin view
  wire logic [2:0] cmd = {RAS_N, CAS_N, WE_N};
  wire logic live = CKE && cke_q;
  wire logic nop = CS_N || (cmd == lcf_pkg::CMD_NOP);
  default clocking cb @(posedge LINK_CLK);
  endclocking
  default disable iff (!ARST_N);
  property p_act;
    live && !CS_N && cmd == lcf_pkg::CMD_ACT &&
    LINK_STATE == lcf_pkg::ST_IDLE
    |=> LINK_STATE == lcf_pkg::ST_ACTIVATING && CMD_VALID
    && CMD_CODE == lcf_pkg::CMD_ACT;
  endproperty
  a_act: assert property (p_act)
    else $error("activate not taken");
  property p_act_time;
    $rose(LINK_STATE == lcf_pkg::ST_ACTIVATING) |->
    (LINK_STATE == lcf_pkg::ST_ACTIVATING) [*3] ##1
    LINK_STATE == lcf_pkg::ST_ACTIVE;
  endproperty
  a_act_time: assert property (p_act_time)
    else $error("activate count wrong");
  property p_pre_time;
    $rose(LINK_STATE == lcf_pkg::ST_PRECHARGING) |->
    (LINK_STATE == lcf_pkg::ST_PRECHARGING) [*3] ##1
    LINK_STATE == lcf_pkg::ST_IDLE;
  endproperty
  a_pre_time: assert property (p_pre_time)
    else $error("precharge count wrong");
  property p_ref_time;
    $rose(LINK_STATE == lcf_pkg::ST_REFRESH) |-> ##11
    LINK_STATE == lcf_pkg::ST_REFRESH ##1 LINK_STATE == lcf_pkg::ST_IDLE;
  endproperty
  a_ref_time: assert property (p_ref_time)
    else $error("refresh count wrong");
  property p_rdac_time;
    $rose(LINK_STATE == lcf_pkg::ST_READ_AC) |->
    (LINK_STATE == lcf_pkg::ST_READ_AC) [*5] ##1
    LINK_STATE == lcf_pkg::ST_IDLE;
  endproperty
  a_rdac_time: assert property (p_rdac_time)
    else $error("auto-close read count wrong");
  property p_wrac_time;
    $rose(LINK_STATE == lcf_pkg::ST_WRITE_AC) |-> ##8
    LINK_STATE == lcf_pkg::ST_WRITE_AC ##1 LINK_STATE == lcf_pkg::ST_IDLE;
  endproperty
  a_wrac_time: assert property (p_wrac_time)
    else $error("auto-close write count wrong");
  property p_hold;
    !CKE && !cke_q && LINK_STATE inside {lcf_pkg::ST_PD_PRE,
    lcf_pkg::ST_PD_ACT, lcf_pkg::ST_SELFREF, lcf_pkg::ST_DEEP_PD}
    |=> $stable(LINK_STATE);
  endproperty
  a_hold: assert property (p_hold)
    else $error("low-power state left with enable low");
  property p_pd_entry;
    !CKE && cke_q && nop && LINK_STATE == lcf_pkg::ST_IDLE
    |=> LINK_STATE == lcf_pkg::ST_PD_PRE;
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("power-down not entered");
  property p_deep_exit;
    CKE && !cke_q && LINK_STATE == lcf_pkg::ST_DEEP_PD
    |=> LINK_STATE == lcf_pkg::ST_IDLE;
  endproperty
  a_deep_exit: assert property (p_deep_exit)
    else $error("deep power-down not left");
  property p_desel;
    live && CS_N && LINK_STATE == lcf_pkg::ST_ACTIVE
    |=> LINK_STATE == lcf_pkg::ST_ACTIVE;
  endproperty
  a_desel: assert property (p_desel)
    else $error("deselect changed state");
  // main scenarios reached
  c_selfref: cover property (LINK_STATE == lcf_pkg::ST_SELFREF);
  c_wrac: cover property (LINK_STATE == lcf_pkg::ST_WRITE_AC);
  c_trunc: cover property (LINK_STATE == lcf_pkg::ST_READ ##1
    LINK_STATE == lcf_pkg::ST_WRITE);
endmodule // lcf_fsm_assertions
bind lcf_fsm lcf_fsm_assertions i_chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
  .LINK_CLK(LINK_CLK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .LINK_STATE(LINK_STATE),
  .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE));

// ---- sim/lpddr_cke_command_fsm_tb_top.sv ----
// ****************************************
// bench top
// ****************************************
module lpddr_cke_command_fsm_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic lclk, cke, cs_n, ras_n, cas_n, we_n, ac, cv, ba, clp, cfo;
  logic [3:0] st, cst;
  logic [2:0] code;
  int miscompares = 0;
  int compares = 0;
  localparam logic [3:0] NP = 4'h7, DS = 4'h8, AT = 4'h3, RD = 4'h5,
    WR = 4'h4, PR = 4'h2, RF = 4'h1, MR = 4'h0, BT = 4'h6;
  // 50 MHz core clock
  always #10 core_clk = ~core_clk;
  lcf_ctl_model i_ctl (.lclk(lclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ac(ac));
  lcf_fsm i_dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .LINK_CLK(lclk),
    .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
    .AUTO_CLOSE(ac), .LINK_STATE(st), .CMD_VALID(cv), .CMD_CODE(code),
    .BURST_ACTIVE(ba), .CORE_STATE(cst), .CORE_LOW_POWER(clp),
    .CORE_FREQ_OK(cfo));
  // shared compare, case equality so unknowns fail
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // command, then a nop so it is taken once; state seen one cycle later
  task automatic go(input logic [3:0] c, input logic k, input logic a,
    input logic [3:0] exp);
    i_ctl.cmd(c, k, a);
    i_ctl.cmd(NP, k, 1'b0);
    chk(st, exp);
  endtask
  // nops until a state shows; the count of cycles must match
  task automatic wt(input logic [3:0] exp, input int n);
    int i;
    i = 0;
    while (st !== exp && i < 40) begin
      i_ctl.cmd(NP, 1'b1, 1'b0);
      i++;
    end
    chk(4'(i), 4'(n));
  endtask
  task automatic t_open;
    go(AT, 1'b1, 1'b0, lcf_pkg::ST_ACTIVATING);
    chk({1'b0, code}, {1'b0, lcf_pkg::CMD_ACT});
    chk({3'h0, cv}, 4'h1);
    wt(lcf_pkg::ST_ACTIVE, 3);
  endtask
  // long truncated read keeps clock change forbidden
  task automatic t_read;
    t_open();
    go(DS, 1'b1, 1'b0, lcf_pkg::ST_ACTIVE);
    repeat (16) i_ctl.cmd(RD, 1'b1, 1'b0);
    i_ctl.cmd(NP, 1'b1, 1'b0);
    chk({ba, clp, cfo, 1'b0}, 4'h8);
    wt(lcf_pkg::ST_ACTIVE, 5);
    go(WR, 1'b1, 1'b0, lcf_pkg::ST_WRITE);
    go(RD, 1'b1, 1'b0, lcf_pkg::ST_READ);
    go(WR, 1'b1, 1'b0, lcf_pkg::ST_WRITE);
    wt(lcf_pkg::ST_ACTIVE, 6);
    go(RD, 1'b1, 1'b0, lcf_pkg::ST_READ);
    go(BT, 1'b1, 1'b0, lcf_pkg::ST_ACTIVE);
    go(WR, 1'b1, 1'b0, lcf_pkg::ST_WRITE);
    go(WR, 1'b1, 1'b0, lcf_pkg::ST_WRITE);
    go(PR, 1'b1, 1'b0, lcf_pkg::ST_PRECHARGING);
    wt(lcf_pkg::ST_IDLE, 3);
    t_open();
    go(RD, 1'b1, 1'b0, lcf_pkg::ST_READ);
    go(PR, 1'b1, 1'b0, lcf_pkg::ST_PRECHARGING);
    wt(lcf_pkg::ST_IDLE, 3);
  endtask
  task automatic t_autoclose;
    t_open();
    go(RD, 1'b1, 1'b1, lcf_pkg::ST_READ_AC);
    wt(lcf_pkg::ST_IDLE, 5);
    t_open();
    go(WR, 1'b1, 1'b1, lcf_pkg::ST_WRITE_AC);
    wt(lcf_pkg::ST_IDLE, 9);
  endtask
  // also the start-up sequence replayed after deep power-down
  task automatic t_idle;
    go(MR, 1'b1, 1'b0, lcf_pkg::ST_MODESET);
    wt(lcf_pkg::ST_IDLE, 2);
    go(RF, 1'b1, 1'b0, lcf_pkg::ST_REFRESH);
    wt(lcf_pkg::ST_IDLE, 12);
  endtask
  task automatic t_power;
    go(NP, 1'b0, 1'b0, lcf_pkg::ST_PD_PRE);
    go(AT, 1'b0, 1'b0, lcf_pkg::ST_PD_PRE);
    repeat (5) @(posedge core_clk);
    #1;
    chk(cst, lcf_pkg::ST_PD_PRE);
    chk({clp, cfo, 2'h0}, 4'hc);
    go(NP, 1'b1, 1'b0, lcf_pkg::ST_IDLE);
    go(RF, 1'b0, 1'b0, lcf_pkg::ST_SELFREF);
    go(NP, 1'b1, 1'b0, lcf_pkg::ST_IDLE);
    go(BT, 1'b0, 1'b0, lcf_pkg::ST_DEEP_PD);
    go(AT, 1'b1, 1'b0, lcf_pkg::ST_IDLE);
    t_idle();
    t_open();
    go(NP, 1'b0, 1'b0, lcf_pkg::ST_PD_ACT);
    go(NP, 1'b1, 1'b0, lcf_pkg::ST_ACTIVE);
  endtask
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence: reset for 5 core cycles, raise enable, run scenarios
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    arst_n = 1'b1;
    chk(st, lcf_pkg::ST_IDLE);
    chk({1'b0, code}, 4'h7);
    go(NP, 1'b1, 1'b0, lcf_pkg::ST_IDLE);
    t_idle();
    t_read();
    t_autoclose();
    t_power();
    print_verdict();
  end
  // the run needs about 1.1 us; cut a hang well beyond that
  initial begin
    #40000;
    miscompares++;
    print_verdict();
  end
endmodule // lpddr_cke_command_fsm_tb_top
